// file: common/deep_sleep_cfg.svh
// constants for deep sleep clock control: both ends
// What this block does
// [R1] light sleep only from grant; hold request
// [R2] bus clock stopped in light sleep: deep
// [R3] restart bus clock, settle 1 ms
// [R4] release sleep request only after settling
// [R5] deep sleep: no snoops, no interrupts
// [R6] platform leaves bus quiet in deep sleep
// [R7] platform sends no snoops near sleep
// [R8] halt and grant keep cache clock, snoop
// [R9] snoop state snoops cache like normal
// [R10] cache clock on light, off deep
// [R11] cache clock back only after settling
// [R12] interrupt clock runs in halt, grant
// [R13] interrupt clock restarts with bus clock
// [R14] toggling complement selects differential mode
// [R15] bus clock edge paces bus interface
// [R16] five supply select outputs to regulator
// [R17] settle counted on restarted bus clock
`ifndef DEEP_SLEEP_CFG_SVH
`define DEEP_SLEEP_CFG_SVH

`define CORE_PERIOD_NS    10
`define BUS_HALF_CYCLES   5
`define PLL_SETTLE_NS     1000000
// bus edges in 1 ms: bus period is 2 * half * core period
`define PLL_SETTLE_EDGES  (`PLL_SETTLE_NS / \
  (`CORE_PERIOD_NS * 2 * `BUS_HALF_CYCLES))
`define PLL_SETTLE_CYCLES (`PLL_SETTLE_NS / `CORE_PERIOD_NS)
// no bus edge for this many core cycles: clock is stopped
`define STOP_DETECT_CYCLES 8'h20
// window for complement toggle detection
`define DIFF_WINDOW_CYCLES 8'h40
`define SETTLE_W          20
`define VID_W             5
// requested core voltage code, arbitrary default
`define VID_CODE          5'h08

`endif

// file: common/deep_sleep_pkg.sv
// types shared by both ends of the deep sleep clock control
package deep_sleep_pkg;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b000,
    ST_HALT   = 3'b001,
    ST_GRANT  = 3'b010,
    ST_SNOOP  = 3'b011,
    ST_LIGHT  = 3'b100,
    ST_DEEP   = 3'b101,
    ST_SETTLE = 3'b110
  } power_state_e;

  typedef enum logic [1:0] {
    BC_RUN     = 2'b00,
    BC_STOPPED = 2'b01,
    BC_RESTART = 2'b10
  } bus_clk_state_e;

endpackage

// file: common/deep_sleep_if.sv
// pins between the device and the platform
`include "deep_sleep_cfg.svh"
interface deep_sleep_if;
  logic                stop_clock_request_n;
  logic                sleep_request_n;
  logic                bus_clk;
  logic                bus_clk_n;
  logic                interrupt_ctrl_clock;
  logic                snoop_req;
  logic                snoop_ack;
  logic                irq;
  logic [`VID_W-1:0]   supply_voltage_select_o;
  logic [`VID_W-1:0]   supply_voltage_select_oe;
  logic [`VID_W-1:0]   supply_voltage_select;

  // open drain with pull-up: low only where driven low
  assign supply_voltage_select =
    supply_voltage_select_o | ~supply_voltage_select_oe;

  modport device (
    input  stop_clock_request_n, sleep_request_n, bus_clk, bus_clk_n,
    input  interrupt_ctrl_clock, snoop_req, irq,
    output snoop_ack, supply_voltage_select_o, supply_voltage_select_oe
  );
  modport platform (
    output stop_clock_request_n, sleep_request_n, bus_clk, bus_clk_n,
    output interrupt_ctrl_clock, snoop_req, irq,
    input  snoop_ack, supply_voltage_select
  );
endinterface

// file: hw/sleep_ctrl_platform.sv
// platform end: bus clock generator, sleep and snoop requests
`include "deep_sleep_cfg.svh"
module sleep_ctrl_platform
  import deep_sleep_pkg::*;
#(
  parameter int unsigned PLL_SETTLE_CYCLES = `PLL_SETTLE_CYCLES
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  deep_sleep_if.platform           link,
  input  wire logic                stop_clock_req,
  input  wire logic                sleep_req,
  input  wire logic                bus_clk_stop,
  input  wire logic                diff_enable,
  input  wire logic                snoop_start,
  input  wire logic                irq_in,
  output logic                     snoop_done,
  output logic                     sleep_released,
  output logic [`VID_W-1:0]        vid_level
);

  bus_clk_state_e    bc_q;
  logic [7:0]        half_q;
  logic              bclk_q;
  logic              tick;
  logic [`SETTLE_W-1:0] settle_q;
  logic              sleep_q;
  logic              hold_ok_q;
  logic              snoop_q;
  logic [1:0]        ack_s;
  logic [`VID_W-1:0] vid_s1;
  logic [`VID_W-1:0] vid_s2;

  // ----------------------------------------------------------
  // bus clock divider and stop/restart
  // ----------------------------------------------------------
  assign tick = (half_q == 8'(`BUS_HALF_CYCLES - 1));

  // half period counter, held at zero while the bus clock is stopped
  always_ff @(posedge core_clk) begin
    if (rst || tick || bc_q == BC_STOPPED) begin
      half_q <= 8'h00;
    end else begin
      half_q <= half_q + 8'h01;
    end
  end

  // stop only low, so the stopped level is defined
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bclk_q <= 1'b0;
    end else if (tick && bc_q != BC_STOPPED) begin
      bclk_q <= ~bclk_q;
    end
  end

  // stop allowed only in light sleep; restart waits out settling
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bc_q     <= BC_RUN;
      settle_q <= '0;
    end else begin
      unique case (bc_q)
        BC_RUN: begin
          if (bus_clk_stop && sleep_q && bclk_q && tick) begin
            bc_q <= BC_STOPPED; // R2
          end
        end
        BC_STOPPED: begin
          if (!bus_clk_stop) begin
            bc_q     <= BC_RESTART; // R3
            settle_q <= '0;
          end
        end
        BC_RESTART: begin
          settle_q <= settle_q + 1'b1;
          if (settle_q == `SETTLE_W'(PLL_SETTLE_CYCLES - 1)) begin
            bc_q <= BC_RUN; // R3
          end
        end
        default: bc_q <= BC_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------
  // sleep request: held to the next bus clock fall, released only when settled
  // ----------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sleep_q   <= 1'b0;
      hold_ok_q <= 1'b0;
    end else begin
      if (!sleep_q) begin
        hold_ok_q <= 1'b0;
      end else if (tick && bclk_q) begin
        hold_ok_q <= 1'b1; // R1
      end
      if (sleep_req && !stop_clock_req) begin
        sleep_q <= sleep_q;
      end
      if (sleep_req && stop_clock_req) begin
        sleep_q <= 1'b1; // R1
      end else if (hold_ok_q && bc_q == BC_RUN && !bus_clk_stop) begin
        sleep_q <= 1'b0; // R4
      end
    end
  end

  assign sleep_released = !sleep_q;

  // ----------------------------------------------------------
  // snoop handshake, blocked around sleep
  // ----------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_s <= 2'b00;
    end else begin
      ack_s <= {ack_s[0], link.snoop_ack};
    end
  end

  // a snoop near sleep is never issued; one already out completes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      snoop_q <= 1'b0;
    end else if (!snoop_q && snoop_start && !sleep_q && !sleep_req) begin
      snoop_q <= 1'b1; // R7
    end else if (snoop_q && ack_s[1]) begin
      snoop_q <= 1'b0;
    end
  end

  assign snoop_done = snoop_q && ack_s[1];

  // regulator samples the open drain select lines
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vid_s1    <= '1;
      vid_s2    <= '1;
      vid_level <= '1;
    end else begin
      vid_s1    <= link.supply_voltage_select;
      vid_s2    <= vid_s1;
      vid_level <= vid_s2;
    end
  end

  // ----------------------------------------------------------
  // pins: bus quiet while sleeping, interrupt clock with bus clock
  // ----------------------------------------------------------
  assign link.stop_clock_request_n = ~(stop_clock_req | sleep_q);
  assign link.sleep_request_n      = ~sleep_q;
  assign link.bus_clk              = bclk_q;
  assign link.bus_clk_n            = diff_enable ? ~bclk_q : 1'b0;
  assign link.interrupt_ctrl_clock = bclk_q; // R12 R13
  assign link.snoop_req            = snoop_q;
  assign link.irq                  = irq_in & ~sleep_q; // R6

endmodule

// file: hw/sleep_ctrl_device.sv
// device end: power states, cache clock gate and bus clock sense
`include "deep_sleep_cfg.svh"
module sleep_ctrl_device
  import deep_sleep_pkg::*;
#(
  parameter int unsigned PLL_SETTLE_EDGES = `PLL_SETTLE_EDGES
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  deep_sleep_if.device             link,
  input  wire logic                halt_req,
  input  wire logic                wake_evt,
  output power_state_e             power_state,
  output logic                     cache_clk_en,
  output logic                     diff_mode,
  output logic                     bus_tick,
  output logic                     irq_taken,
  output logic                     snoop_serviced
);

  // ----------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------
  logic [1:0] bclk_s;
  logic [1:0] bclkn_s;
  logic [1:0] stp_s;
  logic [1:0] slp_s;
  logic [1:0] snp_s;
  logic [1:0] irq_s;
  logic       bclk_d1;
  logic       bclkn_d1;
  logic       irq_d1;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bclk_s  <= 2'b00;
      bclkn_s <= 2'b00;
      stp_s   <= 2'b11;
      slp_s   <= 2'b11;
      snp_s   <= 2'b00;
      irq_s   <= 2'b00;
    end else begin
      bclk_s  <= {bclk_s[0], link.bus_clk};
      bclkn_s <= {bclkn_s[0], link.bus_clk_n};
      stp_s   <= {stp_s[0], link.stop_clock_request_n};
      slp_s   <= {slp_s[0], link.sleep_request_n};
      snp_s   <= {snp_s[0], link.snoop_req};
      irq_s   <= {irq_s[0], link.irq};
    end
  end

  // one more stage for edge detection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bclk_d1  <= 1'b0;
      bclkn_d1 <= 1'b0;
      irq_d1   <= 1'b0;
    end else begin
      bclk_d1  <= bclk_s[1];
      bclkn_d1 <= bclkn_s[1];
      irq_d1   <= irq_s[1];
    end
  end

  logic stop_req;
  logic sleep_req;
  logic true_rise;
  logic comp_edge;
  logic comp_fall;

  assign stop_req  = ~stp_s[1];
  assign sleep_req = ~slp_s[1];
  assign true_rise = bclk_s[1] & ~bclk_d1;
  assign comp_edge = bclkn_s[1] ^ bclkn_d1;
  assign comp_fall = ~bclkn_s[1] & bclkn_d1;

  // ----------------------------------------------------------
  // clock mode detection and bus pacing
  // ----------------------------------------------------------
  logic [7:0] win_q;
  logic       comp_seen_q;
  logic       bus_running;

  // mode is re-judged every window while the bus clock runs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      win_q       <= 8'h00;
      comp_seen_q <= 1'b0;
      diff_mode   <= 1'b0;
    end else if (bus_running) begin
      if (win_q == `DIFF_WINDOW_CYCLES - 8'h01) begin
        win_q       <= 8'h00;
        comp_seen_q <= 1'b0;
        diff_mode   <= comp_seen_q | comp_edge; // R14
      end else begin
        win_q       <= win_q + 8'h01;
        comp_seen_q <= comp_seen_q | comp_edge; // R14
      end
    end
  end

  // diff mode: true rising meets complement falling
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_tick <= 1'b0;
    end else if (diff_mode) begin
      bus_tick <= true_rise & comp_fall; // R15
    end else begin
      bus_tick <= true_rise; // R15
    end
  end

  // ----------------------------------------------------------
  // bus clock stop detection
  // ----------------------------------------------------------
  logic [7:0] idle_q;

  // counts core cycles since the last bus clock edge
  always_ff @(posedge core_clk) begin
    if (rst || (bclk_s[1] ^ bclk_d1)) begin
      idle_q <= 8'h00;
    end else if (idle_q != `STOP_DETECT_CYCLES) begin
      idle_q <= idle_q + 8'h01;
    end
  end

  assign bus_running = (idle_q != `STOP_DETECT_CYCLES);

  // ----------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------
  power_state_e          state_q;
  power_state_e          ret_q;
  logic [`SETTLE_W-1:0]  settle_q;
  logic                  snoop_ok;

  // settle counter only advances on restarted bus clock edges
  always_ff @(posedge core_clk) begin
    if (rst || state_q != ST_SETTLE) begin
      settle_q <= '0;
    end else if (true_rise) begin
      settle_q <= settle_q + 1'b1; // R17
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_NORMAL;
      ret_q   <= ST_GRANT;
    end else begin
      unique case (state_q)
        ST_NORMAL: begin
          if (stop_req) begin
            state_q <= ST_GRANT;
          end else if (halt_req) begin
            state_q <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (stop_req) begin
            state_q <= ST_GRANT;
          end else if (wake_evt) begin
            state_q <= ST_NORMAL;
          end else if (snp_s[1]) begin
            state_q <= ST_SNOOP; // R8
            ret_q   <= ST_HALT;
          end
        end
        ST_GRANT: begin
          if (sleep_req) begin
            state_q <= ST_LIGHT; // R1
          end else if (!stop_req) begin
            state_q <= halt_req ? ST_HALT : ST_NORMAL;
          end else if (snp_s[1]) begin
            state_q <= ST_SNOOP; // R8
            ret_q   <= ST_GRANT;
          end
        end
        ST_SNOOP: begin
          if (!snp_s[1]) begin
            state_q <= ret_q; // R9
          end
        end
        ST_LIGHT: begin
          if (!bus_running) begin
            state_q <= ST_DEEP; // R2
          end else if (!sleep_req) begin
            state_q <= ST_GRANT; // R4
          end
        end
        ST_DEEP: begin
          if (true_rise) begin
            state_q <= ST_SETTLE; // R3
          end
        end
        ST_SETTLE: begin
          if (!bus_running) begin
            state_q <= ST_DEEP; // R2
          end else if (true_rise &&
              settle_q == `SETTLE_W'(PLL_SETTLE_EDGES - 1)) begin
            state_q <= ST_LIGHT; // R3 R17
          end
        end
        default: state_q <= ST_NORMAL;
      endcase
    end
  end

  assign power_state = state_q;

  // cache clock stays on until deep sleep, back only after settling
  assign cache_clk_en = (state_q != ST_DEEP) &&
                        (state_q != ST_SETTLE); // R8 R10 R11

  // ----------------------------------------------------------
  // snoops and interrupts
  // ----------------------------------------------------------
  // no sleep state may answer; a snoop there is the platform's fault
  assign snoop_ok = (state_q == ST_NORMAL) ||
                    (state_q == ST_SNOOP); // R5 R9 R10

  // ack follows request down: four phase handshake
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link.snoop_ack <= 1'b0;
    end else begin
      link.snoop_ack <= snp_s[1] & (link.snoop_ack | snoop_ok); // R5
    end
  end

  assign snoop_serviced = snp_s[1] & ~link.snoop_ack & snoop_ok;

  // rising interrupt is captured in every state except light sleep, deep sleep and settle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_taken <= 1'b0;
    end else begin
      irq_taken <= irq_s[1] & ~irq_d1 &
                   (state_q != ST_LIGHT) && (state_q != ST_DEEP) &&
                   (state_q != ST_SETTLE); // R5 R10
    end
  end

  // ----------------------------------------------------------
  // supply voltage select, open drain
  // ----------------------------------------------------------
  // drive low where the code has a zero; ones float to the pull-up
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link.supply_voltage_select_o  <= '0;
      link.supply_voltage_select_oe <= '0;
    end else begin
      link.supply_voltage_select_o  <= '0; // R16
      link.supply_voltage_select_oe <= ~`VID_CODE; // R16
    end
  end

endmodule

// file: tb/deep_sleep_properties.sv
// assertions on the pins between device and platform
`include "deep_sleep_cfg.svh"
module deep_sleep_properties #(
  parameter int unsigned PLL_SETTLE_CYCLES = `PLL_SETTLE_CYCLES
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              stop_clock_request_n,
  input wire logic              sleep_request_n,
  input wire logic              bus_clk,
  input wire logic              interrupt_ctrl_clock,
  input wire logic              snoop_req,
  input wire logic              snoop_ack,
  input wire logic              irq,
  input wire logic [`VID_W-1:0] supply_voltage_select_oe,
  input wire logic [`VID_W-1:0] supply_voltage_select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  stall_q;
  logic [7:0]  pic_q;
  logic [`SETTLE_W-1:0] run_q;
  logic        bclk_q;
  logic        pclk_q;

  // edge watchers: no bus edge for 32 cycles means the clock is stopped
  always_ff @(posedge core_clk) begin
    bclk_q <= bus_clk;
    pclk_q <= interrupt_ctrl_clock;
    if (rst || bus_clk != bclk_q) stall_q <= 8'h00;
    else if (stall_q != 8'hff) stall_q <= stall_q + 8'h01;
    if (rst || interrupt_ctrl_clock != pclk_q) pic_q <= 8'h00;
    else if (pic_q != 8'hff) pic_q <= pic_q + 8'h01;
    // run time since restart, slack below covers the first half period
    if (rst || stall_q >= `STOP_DETECT_CYCLES) run_q <= '0;
    else if (run_q != '1) run_q <= run_q + 1'b1;
  end

  // ----------------------------------------------------------------
  // pin relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_vid_level_code: assert property (!$past(rst) |->
    supply_voltage_select == `VID_CODE) else $error("select lines wrong");
  a_vid_drive_low: assert property (!$past(rst) |->
    supply_voltage_select_oe == ~`VID_CODE) else $error("select oe wrong");
  // grant must already stand the cycle before sleep is asked for
  a_sleep_needs_grant: assert property ($fell(sleep_request_n) |->
    !$past(stop_clock_request_n)) else $error("sleep without grant");
  a_sleep_min_hold: assert property ($fell(sleep_request_n) |->
    !sleep_request_n [*8] ##1 !sleep_request_n ##1 !sleep_request_n)
    else $error("sleep request too short");
  a_snoop_ack_time: assert property ($rose(snoop_req) |->
    ##[3:4] snoop_ack) else $error("snoop not acknowledged");
  a_snoop_ack_drop: assert property ($fell(snoop_req) |->
    ##[3:4] !snoop_ack) else $error("snoop ack stuck");
  a_bus_quiet_deep: assert property (stall_q >= `STOP_DETECT_CYCLES
    |-> $stable(snoop_req) && $stable(irq) && $stable(stop_clock_request_n))
    else $error("bus moved while clock stopped");
  a_settle_before_wake: assert property ($rose(sleep_request_n)
    |-> run_q >= PLL_SETTLE_CYCLES - 10) else $error("released early");
  a_pic_clock_runs: assert property (sleep_request_n
    |-> pic_q < 8'hc8) else $error("interrupt clock stopped");
  a_pic_restart: assert property ((stall_q >= `STOP_DETECT_CYCLES)
    ##1 (stall_q == 8'h00) |-> ##[0:200] $changed(interrupt_ctrl_clock))
    else $error("interrupt clock not restarted");

  c_deep: cover property (stall_q == `STOP_DETECT_CYCLES && !sleep_request_n);
  c_snoop: cover property ($rose(snoop_ack));
  c_wake: cover property ($rose(sleep_request_n));
endmodule

// file: tb/deep_sleep_clock_control_tb.sv
// self-checking bench: both ends joined, plus a device faced by the bench
`include "deep_sleep_cfg.svh"
module deep_sleep_clock_control_tb import deep_sleep_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE_EDGES = 8;
  localparam int SETTLE_CYC   = 200;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic              stop_clock_req, sleep_req, bus_clk_stop, diff_enable;
  logic              snoop_start, irq_in, halt_req, wake_evt;
  logic              snoop_done, sleep_released;
  logic [`VID_W-1:0] vid_level;
  power_state_e      power_state, power_state2;
  logic              cache_clk_en, diff_mode, bus_tick, irq_taken, svc_p;
  logic              cache2, diff_mode2, tick2, irq_taken2, svc2_p;
  int                error_cnt = 0, checked = 0, ticks = 0, svc = 0;
  int                irqs = 0, bad2 = 0, t0, k;
  logic [31:0]       rnd = 32'd19;

  deep_sleep_if link();
  deep_sleep_if link2();
  // faulty platform: bench drives the pins, clocks copied from the real one
  assign link2.bus_clk = link.bus_clk;
  assign link2.interrupt_ctrl_clock = link.interrupt_ctrl_clock;

  sleep_ctrl_platform #(.PLL_SETTLE_CYCLES(SETTLE_CYC)) sleep_ctrl_platform_i (
    .core_clk(core_clk), .rst(rst), .link(link),
    .stop_clock_req(stop_clock_req), .sleep_req(sleep_req),
    .bus_clk_stop(bus_clk_stop), .diff_enable(diff_enable),
    .snoop_start(snoop_start), .irq_in(irq_in), .snoop_done(snoop_done),
    .sleep_released(sleep_released), .vid_level(vid_level));
  sleep_ctrl_device #(.PLL_SETTLE_EDGES(SETTLE_EDGES)) sleep_ctrl_device_i (
    .core_clk(core_clk), .rst(rst), .link(link), .halt_req(halt_req),
    .wake_evt(wake_evt), .power_state(power_state),
    .cache_clk_en(cache_clk_en), .diff_mode(diff_mode), .bus_tick(bus_tick),
    .irq_taken(irq_taken), .snoop_serviced(svc_p));
  sleep_ctrl_device #(.PLL_SETTLE_EDGES(SETTLE_EDGES)) sleep_ctrl_device_b_i (
    .core_clk(core_clk), .rst(rst), .link(link2), .halt_req(1'b0),
    .wake_evt(1'b0), .power_state(power_state2), .cache_clk_en(cache2),
    .diff_mode(diff_mode2), .bus_tick(tick2), .irq_taken(irq_taken2),
    .snoop_serviced(svc2_p));
  deep_sleep_properties #(.PLL_SETTLE_CYCLES(SETTLE_CYC)) props_i (
    .core_clk(core_clk), .rst(rst),
    .stop_clock_request_n(link.stop_clock_request_n),
    .sleep_request_n(link.sleep_request_n), .bus_clk(link.bus_clk),
    .interrupt_ctrl_clock(link.interrupt_ctrl_clock),
    .snoop_req(link.snoop_req), .snoop_ack(link.snoop_ack), .irq(link.irq),
    .supply_voltage_select_oe(link.supply_voltage_select_oe),
    .supply_voltage_select(link.supply_voltage_select));

  always #5 core_clk = ~core_clk;

  // pulse counters, sampled mid-cycle where outputs have settled
  always @(negedge core_clk) begin
    if (bus_tick === 1'b1) ticks++;
    if (svc_p === 1'b1) svc++;
    if (irq_taken === 1'b1) irqs++;
    if (svc2_p === 1'b1 || irq_taken2 === 1'b1 || tick2 === 1'b1) bad2++;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic note(input logic ok, input logic [31:0] got, exp);
    checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_state(input power_state_e got, exp);
    note(got === exp, 32'(got), 32'(exp));
  endtask
  task automatic chk_bit(input logic got, exp);
    note(got === exp, 32'(got), 32'(exp));
  endtask
  task automatic chk_vid(input logic [`VID_W-1:0] got, exp);
    note(got === exp, 32'(got), 32'(exp));
  endtask
  task automatic chk_cnt(input int got, lo, hi);
    note(got >= lo && got <= hi, got, lo);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // model: cache clock stops only while the clock is down or settling
  task automatic wait_state(input power_state_e exp, input int lim);
    k = 0;
    while (power_state !== exp && k < lim) begin
      @(negedge core_clk);
      k++;
    end
    chk_state(power_state, exp);
    chk_bit(cache_clk_en, exp != ST_DEEP && exp != ST_SETTLE);
    // hand back on a rising edge so callers drive there
    @(posedge core_clk);
  endtask
  task automatic snoop(input power_state_e home);
    t0 = svc;
    rnd = xs(rnd);
    repeat (1 + rnd % 8) @(posedge core_clk);
    snoop_start <= 1'b1;
    @(posedge core_clk);
    snoop_start <= 1'b0;
    if (home != ST_NORMAL) wait_state(ST_SNOOP, 20);
    k = 0;
    while (snoop_done !== 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    chk_bit(snoop_done, 1'b1);
    repeat (8) @(posedge core_clk); // ack falls 3 edges after request
    wait_state(home, 20);
    chk_cnt(svc - t0, 1, 1);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {stop_clock_req, sleep_req, bus_clk_stop, snoop_start} = 4'h0;
    {irq_in, halt_req, wake_evt, diff_enable} = 4'h1;
    {link2.stop_clock_request_n, link2.sleep_request_n} = 2'h3;
    {link2.snoop_req, link2.irq, link2.bus_clk_n} = 3'h0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (100) @(posedge core_clk);
    chk_bit(diff_mode, 1'b1);
    chk_bit(diff_mode2, 1'b0);
    chk_vid(vid_level, `VID_CODE);
    t0 = ticks;
    repeat (100) @(posedge core_clk);
    chk_cnt(ticks - t0, 9, 11);
    link2.sleep_request_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk_state(power_state2, ST_NORMAL);
    link2.sleep_request_n <= 1'b1;
    t0 = irqs;
    irq_in <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk_cnt(irqs - t0, 1, 1);
    irq_in <= 1'b0;
    repeat (3) snoop(ST_NORMAL);
    halt_req <= 1'b1;
    wait_state(ST_HALT, 20);
    snoop(ST_HALT);
    halt_req <= 1'b0;
    wake_evt <= 1'b1;
    wait_state(ST_NORMAL, 20);
    wake_evt <= 1'b0;
    stop_clock_req <= 1'b1;
    link2.stop_clock_request_n <= 1'b0;
    wait_state(ST_GRANT, 20);
    snoop(ST_GRANT);
    sleep_req <= 1'b1;
    link2.sleep_request_n <= 1'b0;
    wait_state(ST_LIGHT, 40);
    bus_clk_stop <= 1'b1;
    wait_state(ST_DEEP, 100);
    chk_state(power_state2, ST_DEEP);
    chk_bit(cache2, 1'b0);
    t0 = ticks;
    k = bad2;
    link2.snoop_req <= 1'b1;
    link2.irq <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk_cnt(ticks - t0, 0, 0);
    chk_bit(link2.snoop_ack, 1'b0);
    chk_cnt(bad2 - k, 0, 0);
    link2.snoop_req <= 1'b0;
    link2.irq <= 1'b0;
    bus_clk_stop <= 1'b0;
    wait_state(ST_SETTLE, 40);
    t0 = ticks;
    wait_state(ST_LIGHT, 200);
    chk_cnt(ticks - t0, SETTLE_EDGES - 1, SETTLE_EDGES + 1);
    sleep_req <= 1'b0;
    wait_state(ST_GRANT, 400);
    chk_bit(sleep_released, 1'b1);
    stop_clock_req <= 1'b0;
    wait_state(ST_NORMAL, 40);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk_state(power_state, ST_NORMAL);
    rst <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk_vid(vid_level, `VID_CODE);
    end_of_test();
  end
endmodule
